/* hw/mef_status_flags.v */
`timescale 1ns/1ps
`include "mef_defs.vh"

module mef_status_flags #(
   parameter FREQ_W = 16
) (
   // clock and reset
   input  wire                   sys_clk,
   input  wire                   sys_rst,
   // register port from the serial interface decoder
   input  wire [`MEF_ADDR_W-1:0] reg_addr,
   input  wire                   reg_wr_en,
   input  wire [15:0]            reg_wr_data,
   input  wire                   reg_rd_en,
   output reg  [15:0]            reg_rd_data_ff,
   output reg                    reg_rd_valid_ff,
   // measured frequency and its programmed thresholds
   input  wire [FREQ_W-1:0]      freq_meas,
   input  wire [FREQ_W-1:0]      freq_hi_thresh,
   input  wire [FREQ_W-1:0]      freq_lo_thresh,
   // per-phase detector levels, bit 2 = phase A, bit 0 = phase C
   input  wire [2:0]             sag_det,
   input  wire [2:0]             phase_loss_det,
   // energy accumulator sign bits, one = negative
   input  wire                   total_reactive_neg,
   input  wire [2:0]             reactive_neg,
   input  wire                   total_active_neg,
   input  wire [2:0]             active_neg,
   // first event state word, live levels from the event detectors
   input  wire [15:0]            event_state_word_0,
   // registered second event state word and interrupt request
   output reg  [15:0]            event_state_word_1_ff,
   output reg                    irq_req_ff
);

   ////////////////////////////////////////////////////////////////////////
   // address decode helper, used for every write target; reads decode in the case mux
   function addr_hit;
      input [`MEF_ADDR_W-1:0] addr;
      input [`MEF_ADDR_W-1:0] ofs;
      begin
         addr_hit = (addr == ofs);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // internal state
   reg  [15:0] state0_ff;          // registered copy of first state word
   reg         primed_ff;          // low in the first cycle after reset
   reg  [15:0] flags0_ff;          // change flags word 0
   reg  [15:0] flags1_ff;          // change flags word 1
   reg  [15:0] enable0_ff;         // interrupt enables word 0
   reg  [15:0] enable1_ff;         // interrupt enables word 1

   reg  [15:0] nxt_state1;
   wire [15:0] nxt_flags0;
   wire [15:0] nxt_flags1;
   wire [15:0] change0;
   wire [15:0] change1;
   wire [15:0] clear0;
   wire [15:0] clear1;
   reg  [15:0] nxt_rd_data;
   wire        nxt_irq;

   ////////////////////////////////////////////////////////////////////////
   // assemble the second event state word from the live conditions
   always @* begin
      nxt_state1 = `MEF_RST_WORD;
      nxt_state1[`MEF_B_OVER_FREQ] = (freq_meas > freq_hi_thresh);
      nxt_state1[`MEF_B_UNDER_FREQ] = (freq_meas < freq_lo_thresh);
      nxt_state1[`MEF_B_SAG_A] = sag_det[2];
      nxt_state1[`MEF_B_SAG_B] = sag_det[1];
      nxt_state1[`MEF_B_SAG_C] = sag_det[0];
      nxt_state1[`MEF_B_LOSS_A] = phase_loss_det[2];
      nxt_state1[`MEF_B_LOSS_B] = phase_loss_det[1];
      nxt_state1[`MEF_B_LOSS_C] = phase_loss_det[0];
      nxt_state1[`MEF_B_TOT_REACT_SIGN] = total_reactive_neg;
      nxt_state1[`MEF_B_REACT_SIGN_A] = reactive_neg[2];
      nxt_state1[`MEF_B_REACT_SIGN_B] = reactive_neg[1];
      nxt_state1[`MEF_B_REACT_SIGN_C] = reactive_neg[0];
      nxt_state1[`MEF_B_TOT_ACT_SIGN] = total_active_neg;
      nxt_state1[`MEF_B_ACT_SIGN_A] = active_neg[2];
      nxt_state1[`MEF_B_ACT_SIGN_B] = active_neg[1];
      nxt_state1[`MEF_B_ACT_SIGN_C] = active_neg[0];
   end

   ////////////////////////////////////////////////////////////////////////
   // state registers; the primed flop stops reset values from looking
   // like a transition when the live levels come up non-zero
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         event_state_word_1_ff <= `MEF_RST_WORD;
         state0_ff             <= `MEF_RST_WORD;
         primed_ff             <= 1'b0;
      end else begin
         event_state_word_1_ff <= nxt_state1;
         state0_ff             <= event_state_word_0;
         primed_ff             <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // host write-one-to-clear masks
   assign clear0 = (reg_wr_en && addr_hit(reg_addr, `MEF_OFS_FLAGS0)) ?
                   reg_wr_data : `MEF_RST_WORD;
   assign clear1 = (reg_wr_en && addr_hit(reg_addr, `MEF_OFS_FLAGS1)) ?
                   reg_wr_data : `MEF_RST_WORD;

   ////////////////////////////////////////////////////////////////////////
   // per-bit edge detect and sticky flag update, same bit positions
   // in state and flag words so one loop covers all of them
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_flag
         // either edge of the registered level counts as a change
         assign change0[gi] = primed_ff &&
                              (event_state_word_0[gi] != state0_ff[gi]);
         assign change1[gi] = primed_ff &&
                              (nxt_state1[gi] != event_state_word_1_ff[gi]);
         // set beats clear in the same cycle
         assign nxt_flags0[gi] = (flags0_ff[gi] & ~clear0[gi]) |
                                 change0[gi];
         assign nxt_flags1[gi] = (flags1_ff[gi] & ~clear1[gi]) |
                                 change1[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // flag and enable registers
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         flags0_ff  <= `MEF_RST_WORD;
         flags1_ff  <= `MEF_RST_WORD;
         enable0_ff <= `MEF_RST_WORD;
         enable1_ff <= `MEF_RST_WORD;
      end else begin
         flags0_ff <= nxt_flags0;
         flags1_ff <= nxt_flags1;
         if (reg_wr_en && addr_hit(reg_addr, `MEF_OFS_ENABLE0)) begin
            enable0_ff <= reg_wr_data;
         end
         if (reg_wr_en && addr_hit(reg_addr, `MEF_OFS_ENABLE1)) begin
            enable1_ff <= reg_wr_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt request: any flag whose enable is set
   assign nxt_irq = |(nxt_flags0 & enable0_ff) |
                    |(nxt_flags1 & enable1_ff);

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         irq_req_ff <= 1'b0;
      end else begin
         irq_req_ff <= nxt_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data mux; unmapped indices read as zero
   always @* begin
      case (reg_addr)
         `MEF_OFS_STATE1:  nxt_rd_data = event_state_word_1_ff;
         `MEF_OFS_FLAGS0:  nxt_rd_data = flags0_ff;
         `MEF_OFS_FLAGS1:  nxt_rd_data = flags1_ff;
         `MEF_OFS_ENABLE0: nxt_rd_data = enable0_ff;
         `MEF_OFS_ENABLE1: nxt_rd_data = enable1_ff;
         default:          nxt_rd_data = `MEF_RST_WORD;
      endcase
   end

   // read answer one cycle after the strobe, held until the next read
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         reg_rd_data_ff  <= `MEF_RST_WORD;
         reg_rd_valid_ff <= 1'b0;
      end else begin
         reg_rd_valid_ff <= reg_rd_en;
         if (reg_rd_en) begin
            reg_rd_data_ff <= nxt_rd_data;
         end
      end
   end

endmodule // mef_status_flags

/* pkg/mef_defs.vh */
`ifndef MEF_DEFS_VH
`define MEF_DEFS_VH

// register word indices on the device register port
`define MEF_ADDR_W            7
`define MEF_OFS_STATE1        7'h72
`define MEF_OFS_FLAGS0        7'h73
`define MEF_OFS_FLAGS1        7'h74
`define MEF_OFS_ENABLE0       7'h75
`define MEF_OFS_ENABLE1       7'h76

// reset values
`define MEF_RST_WORD          16'h0000

// second event state word field positions
`define MEF_B_OVER_FREQ       15
`define MEF_B_SAG_A           14
`define MEF_B_SAG_B           13
`define MEF_B_SAG_C           12
`define MEF_B_UNDER_FREQ      11
`define MEF_B_LOSS_A          10
`define MEF_B_LOSS_B          9
`define MEF_B_LOSS_C          8
`define MEF_B_TOT_REACT_SIGN  7
`define MEF_B_REACT_SIGN_A    6
`define MEF_B_REACT_SIGN_B    5
`define MEF_B_REACT_SIGN_C    4
`define MEF_B_TOT_ACT_SIGN    3
`define MEF_B_ACT_SIGN_A      2
`define MEF_B_ACT_SIGN_B      1
`define MEF_B_ACT_SIGN_C      0

// first event state word field positions (change flags word 0)
`define MEF_B_OVERCURRENT_A   15
`define MEF_B_OVERVOLTAGE_A   12
`define MEF_B_VOLT_SEQUENCE   9
`define MEF_B_CURR_SEQUENCE   8
`define MEF_B_NEUTRAL_OC      7
`define MEF_B_NOLOAD_REACT    6
`define MEF_B_NOLOAD_ACT      5
`define MEF_B_NOLOAD_APP      4
`define MEF_B_PULSE_OUT1      3

`endif

/* dv/mef_status_checker_properties.sv */
`timescale 1ns/1ps
// port-level checks of the status flag block
module mef_status_checker #(
   parameter FREQ_W = 16
) (
   // clock and reset
   input wire              sys_clk,
   input wire              sys_rst,
   // register port
   input wire [6:0]        reg_addr,
   input wire              reg_rd_en,
   input wire              reg_wr_en,
   input wire [15:0]       reg_rd_data_ff,
   input wire              reg_rd_valid_ff,
   // live inputs and outputs
   input wire [FREQ_W-1:0] freq_meas,
   input wire [FREQ_W-1:0] freq_hi_thresh,
   input wire [FREQ_W-1:0] freq_lo_thresh,
   input wire [2:0]        sag_det,
   input wire [2:0]        phase_loss_det,
   input wire              total_reactive_neg,
   input wire [2:0]        reactive_neg,
   input wire              total_active_neg,
   input wire [2:0]        active_neg,
   input wire [15:0]       event_state_word_1_ff,
   input wire              irq_req_ff
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////
   rd_answer_a: assert property (reg_rd_en |=> reg_rd_valid_ff)
      else $error("read not answered");
   rd_single_a: assert property (!reg_rd_en |=> !reg_rd_valid_ff)
      else $error("stray read valid");
   rd_hold_a: assert property (!reg_rd_en |=> $stable(reg_rd_data_ff))
      else $error("read data moved");
   unmapped_zero_a: assert property (reg_rd_en && reg_addr == 7'h10
      |=> reg_rd_data_ff == 16'h0000) else $error("unmapped read not 0");
   over_freq_a: assert property (1'b1 |=> event_state_word_1_ff[15] ==
      $past(freq_meas > freq_hi_thresh)) else $error("over freq bit");
   under_freq_a: assert property (1'b1 |=> event_state_word_1_ff[11] ==
      $past(freq_meas < freq_lo_thresh)) else $error("under freq bit");
   sag_map_a: assert property (##1 event_state_word_1_ff[14:12] ==
      $past(sag_det)) else $error("sag bits");
   loss_map_a: assert property (##1 event_state_word_1_ff[10:8] ==
      $past(phase_loss_det)) else $error("loss bits");
   sign_map_a: assert property (##1
      event_state_word_1_ff[7:0] ==
      $past({total_reactive_neg, reactive_neg, total_active_neg,
      active_neg})) else $error("sign bits");
   // main scenarios seen
   cover property (reg_wr_en);
   cover property ($rose(irq_req_ff));
   cover property ($rose(sag_det[2]));
endmodule // mef_status_checker
bind mef_status_flags mef_status_checker #(.FREQ_W(FREQ_W)) chk (.*);

/* dv/mef_host_model.sv */
`timescale 1ns/1ps
// host side of the register port, as left by the serial decoder
module mef_host_model (
   // clock and answer
   input  wire        sys_clk,
   input  wire [15:0] reg_rd_data_ff,
   input  wire        reg_rd_valid_ff,
   // requests
   output reg  [6:0]  reg_addr = 7'h00,
   output reg         reg_wr_en = 1'b0,
   output reg  [15:0] reg_wr_data = 16'h0000,
   output reg         reg_rd_en = 1'b0
);
   // one-cycle write strobe, data inverted once released
   task wr(input [6:0] a, input [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wr_data <= d;
      reg_wr_en <= 1'b1;
      @(posedge sys_clk);
      reg_wr_en <= 1'b0;
      reg_wr_data <= ~d;
   endtask
   // one-cycle read strobe, bounded wait for the answer
   task rd(input [6:0] a, output [15:0] d, output ok);
      integer i;
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge sys_clk);
      reg_rd_en <= 1'b0;
      ok = 1'b0;
      for (i = 0; i < 4 && !ok; i++) begin
         @(posedge sys_clk);
         ok = (reg_rd_valid_ff === 1'b1);
      end
      d = reg_rd_data_ff;
   endtask
endmodule // mef_host_model

/* dv/metering_event_status_flags_test.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
   n_mismatch++; $display("wrong value at %0t: %h not %h", $time, g, e); end end
module metering_event_status_flags_test;
   logic sys_clk, sys_rst, reg_wr_en, reg_rd_en, rd_valid, irq, tr, ta, ok;
   logic [6:0] reg_addr;
   logic [15:0] wr_data, rd_data, esw0, esw1, fm, got;
   logic [2:0] sag, loss, rn, an;
   integer n_mismatch = 0, samples_checked = 0;
   // device under test and host model
   mef_status_flags DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(wr_data),
      .reg_rd_en(reg_rd_en), .reg_rd_data_ff(rd_data),
      .reg_rd_valid_ff(rd_valid), .freq_meas(fm), .freq_hi_thresh(16'h1000),
      .freq_lo_thresh(16'h0400), .sag_det(sag), .phase_loss_det(loss),
      .total_reactive_neg(tr), .reactive_neg(rn), .total_active_neg(ta),
      .active_neg(an), .event_state_word_0(esw0),
      .event_state_word_1_ff(esw1), .irq_req_ff(irq));
   mef_host_model host (.sys_clk(sys_clk), .reg_rd_data_ff(rd_data),
      .reg_rd_valid_ff(rd_valid), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_wr_data(wr_data), .reg_rd_en(reg_rd_en));
   // verdict and end of run
   task finish_test;
      if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // read a word and compare it
   task chk_rd(input [6:0] a, input [15:0] e);
      host.rd(a, got, ok);
      `CHK(ok, 1'b1)
      `CHK(got, e)
   endtask
   // set the live conditions, then let the state word catch up
   task set_live(input [15:0] f, input [2:0] s, l, input t, input [2:0] r,
      input u, input [2:0] v);
      @(posedge sys_clk);
      {fm, sag, loss, tr, rn, ta, an} <= {f, s, l, t, r, u, v};
      repeat (2) @(posedge sys_clk);
   endtask
   // 50 ns clock and watchdog
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_mismatch++;
      finish_test;
   end
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {sys_rst, fm, sag, loss, tr, rn, ta, an, esw0} = {1'b1, 16'h0800, 30'h0};
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      chk_rd(7'h73, 16'h0000);
      chk_rd(7'h74, 16'h0000);
      chk_rd(7'h75, 16'h0000);
      set_live(16'h2000, 3'b101, 3'b010, 1'b1, 3'b001, 1'b0, 3'b110);
      chk_rd(7'h72, 16'hd296);
      chk_rd(7'h74, 16'hd296);
      set_live(16'h0100, 3'b000, 3'b000, 1'b0, 3'b000, 1'b0, 3'b000);
      chk_rd(7'h72, 16'h0800);
      chk_rd(7'h74, 16'hda96);
      host.wr(7'h74, 16'h00ff);
      host.wr(7'h74, 16'h0000);
      host.wr(7'h72, 16'hffff);
      chk_rd(7'h74, 16'hda00);
      chk_rd(7'h72, 16'h0800);
      set_live(16'h0800, 3'b000, 3'b000, 1'b0, 3'b000, 1'b0, 3'b000);
      host.wr(7'h74, 16'hffff);
      chk_rd(7'h74, 16'h0000);
      esw0 <= 16'ha5c3;
      chk_rd(7'h73, 16'ha5c3);
      host.wr(7'h73, 16'hffff);
      chk_rd(7'h73, 16'h0000);
      host.wr(7'h76, 16'h4000);
      chk_rd(7'h76, 16'h4000);
      set_live(16'h0800, 3'b100, 3'b000, 1'b0, 3'b000, 1'b0, 3'b000);
      `CHK(irq, 1'b1)
      fork
         host.wr(7'h74, 16'h4000);
         set_live(16'h0800, 3'b000, 3'b000, 1'b0, 3'b000, 1'b0, 3'b000);
      join
      chk_rd(7'h74, 16'h4000);
      host.wr(7'h74, 16'h4000);
      set_live(16'h0800, 3'b010, 3'b000, 1'b0, 3'b000, 1'b0, 3'b000);
      `CHK(irq, 1'b0)
      chk_rd(7'h74, 16'h2000);
      chk_rd(7'h10, 16'h0000);
      finish_test;
   end
endmodule // metering_event_status_flags_test
